// [src/ptlm_pkg.sv]
// Constants and field layout shared by the press tonnage limit monitor.
package ptlm_pkg;
    // ==========================================================
    // Sizes
    // ==========================================================
    localparam int NCH    = 4;   // Sensor channels.
    localparam int TW     = 16;  // Signed tonnage width.
    localparam int NLIM   = 6;   // Limits per channel.
    localparam int NREF   = 10;  // Stored reference sets.
    localparam int REF_AW = 4;   // Reference index width.
    localparam int SEL_W  = 4;   // Programming selector width.

    // ==========================================================
    // Programming selectors
    // ==========================================================
    localparam logic [3:0] SEL_POS   = 4'h0;  // Positive overload limit.
    localparam logic [3:0] SEL_NEG   = 4'h1;  // Reverse tonnage limit (magnitude).
    localparam logic [3:0] SEL_DHI   = 4'h2;  // Die band high deviation.
    localparam logic [3:0] SEL_DLO   = 4'h3;  // Die band low deviation.
    localparam logic [3:0] SEL_PHI   = 4'h4;  // Process band high deviation.
    localparam logic [3:0] SEL_PLO   = 4'h5;  // Process band low deviation.
    localparam logic [3:0] SEL_OPT   = 4'h6;  // Per-channel option bits.
    localparam logic [3:0] SEL_REF   = 4'h7;  // Reference index (privileged).
    localparam logic [3:0] SEL_AVG   = 4'h8;  // Averaging shift (privileged).
    localparam logic [3:0] SEL_LEARN = 4'h9;  // Start learning (privileged).

    // ==========================================================
    // Option bit positions
    // ==========================================================
    localparam int OPT_NEG_EN  = 0;  // Reverse tonnage check on.
    localparam int OPT_DIE_EN  = 1;  // Die band check on.
    localparam int OPT_PROC_EN = 2;  // Process band check on.
    localparam int OPT_DIE_PCT = 3;  // Die deviations in percent.
    localparam int OPT_PRC_PCT = 4;  // Process deviations in percent.
    localparam int OPT_W       = 5;

    // ==========================================================
    // Reset values and fixed figures
    // ==========================================================
    localparam logic [15:0] RST_LIMIT   = 16'h7FFF;  // Limits open after reset.
    localparam logic [4:0]  RST_OPT     = 5'h00;     // All optional checks off.
    localparam logic [2:0]  RST_AVG     = 3'h2;      // Average over 4 strokes.
    localparam logic [2:0]  AVG_MAX     = 3'h4;      // Longest average, 16 strokes.
    localparam logic [2:0]  LEARN_N     = 3'h4;      // Strokes per learn.
    localparam int          LEARN_SH    = 2;         // log2 of LEARN_N.
    localparam logic [15:0] DRIFT_LIMIT = 16'h0005;  // Unloaded reading bound, tons.
    localparam int          PCT_FULL    = 100;

    typedef logic signed [TW-1:0] ptlm_ton_t;
endpackage

// [src/ptlm_ref_mem.sv]
// Reference tonnage store: one word of all channel peaks per entry.
`timescale 1ns/1ps
`default_nettype none
module ptlm_ref_mem
    import ptlm_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                we,
    input  wire logic [REF_AW-1:0]   waddr,
    input  wire logic [NCH*TW-1:0]   wdata,
    input  wire logic [REF_AW-1:0]   raddr,
    output logic      [NCH*TW-1:0]   rdata_q
);
    // ==========================================================
    // Storage
    // ==========================================================
    logic [NCH*TW-1:0] mem [NREF];  // Entries, no reset; validity is tracked outside.

    // Write port; out-of-range indices are dropped.
    always_ff @(posedge clk) begin
        if (we && (waddr < REF_AW'(NREF))) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read keeps the comparison path short.
    always_ff @(posedge clk) begin
        if (raddr < REF_AW'(NREF)) begin
            rdata_q <= mem[raddr];
        end else begin
            rdata_q <= '0;
        end
    end
endmodule
`default_nettype wire

// [src/ptlm_monitor.sv]
// Press tonnage limit monitor: limits, bands, relays, counters.
// Operation
// (R1) Four channels, each checked on its own.
// (R2) Six limits per channel; all but overload disableable.
// (R3) Overload limit in tons, always compared.
// (R4) Reverse tonnage limit, can be switched off.
// (R5) Die band around reference, tons or percent.
// (R6) Ten stored reference sets selectable.
// (R7) Process band around base, tons or percent.
// (R8) Base is running average, programmable length.
// (R9) Learn mode computes the die reference.
// (R10) Overload and reverse relays drop on excess.
// (R11) Over relay drops above die/process high.
// (R12) Under relay drops below die/process low.
// (R13) Count every hit and every good part.
// (R14) Good parts reported as percent of hits.
// (R15) Changes refused without program enable.
// (R16) Privileged settings need both supervisory inputs.
// (R17) Latched faults clear only during fault reset.
// (R18) Press marks strokes by cycle rising edge.
// (R19) Detect broken wires and drift, flag fault.
// (R20) Relays energized when healthy, latch when dropped.
// (R21) Cycle edge finalises stroke and updates counters.
`timescale 1ns/1ps
`default_nettype none
module ptlm_monitor
    import ptlm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              sample_valid,
    input  wire logic [NCH*TW-1:0] sample_ton,
    input  wire logic [NCH-1:0]    chan_installed,
    input  wire logic              cfg_wr,
    input  wire logic [1:0]        cfg_chan,
    input  wire logic [SEL_W-1:0]  cfg_sel,
    input  wire logic [TW-1:0]     cfg_data,
    input  wire logic              program_enable,
    input  wire logic              supv1,
    input  wire logic              supv2,
    input  wire logic              fault_reset,
    input  wire logic              press_cycle,
    input  wire logic [NCH-1:0]    sensor_open,
    output logic                   relay_pos_q,
    output logic                   relay_neg_q,
    output logic                   relay_over_q,
    output logic                   relay_under_q,
    output logic                   relay_fault_q,
    output logic [NCH-1:0]         chan_fault_q,
    output logic [31:0]            hit_count_q,
    output logic [31:0]            good_count_q,
    output logic [6:0]             good_pct_q,
    output logic                   learn_busy_q,
    output logic                   cfg_refused_q
);
    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    localparam int PW = 5 + NCH;
    logic [PW-1:0] pin_m_q;    // First stage, read by the second only.
    logic [PW-1:0] pin_s_q;    // Second stage, safe to use.
    logic          cyc_prev_q; // Last synchronised cycle level.

    // Two flops per pin; contacts are asynchronous to clk.
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_m_q <= '0;
            pin_s_q <= '0;
        end else begin
            pin_m_q <= {sensor_open, press_cycle, fault_reset, supv2, supv1, program_enable};
            pin_s_q <= pin_m_q;
        end
    end

    logic prog_s, supv_s, frst_s, cyc_s;
    logic [NCH-1:0] open_s;
    assign prog_s = pin_s_q[0];
    assign supv_s = pin_s_q[1] & pin_s_q[2];       // [R16]
    assign frst_s = pin_s_q[3];
    assign cyc_s  = pin_s_q[4];
    assign open_s = pin_s_q[PW-1:5];

    // Edge detector works on the second stage only.
    always_ff @(posedge clk) begin
        if (rst) begin
            cyc_prev_q <= 1'b0;
        end else begin
            cyc_prev_q <= cyc_s;
        end
    end
    logic stroke_edge;
    assign stroke_edge = cyc_s & ~cyc_prev_q;       // [R18]

    // ==========================================================
    // Programmed values
    // ==========================================================
    logic [TW-1:0]     lim_q [NCH][NLIM]; // Six limits per channel.
    logic [OPT_W-1:0]  opt_q [NCH];       // Enables and unit choices.
    logic [REF_AW-1:0] ref_sel_q;         // Active reference entry.
    logic [2:0]        avg_sh_q;          // Average length as a shift.
    logic              priv_sel, wr_ok, learn_cmd;

    assign priv_sel  = (cfg_sel == SEL_REF) || (cfg_sel == SEL_AVG) || (cfg_sel == SEL_LEARN);
    assign wr_ok     = cfg_wr && prog_s && (!priv_sel || supv_s);  // [R15] [R16]
    assign learn_cmd = wr_ok && (cfg_sel == SEL_LEARN);

    // Accepted writes update one field; refused ones flag for one cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int c = 0; c < NCH; c++) begin
                for (int l = 0; l < NLIM; l++) begin
                    lim_q[c][l] <= RST_LIMIT;
                end
                opt_q[c] <= RST_OPT;
            end
            ref_sel_q     <= '0;
            avg_sh_q      <= RST_AVG;
            cfg_refused_q <= 1'b0;
        end else begin
            cfg_refused_q <= cfg_wr && !wr_ok;     // [R15]
            if (wr_ok) begin
                case (cfg_sel)
                    SEL_POS, SEL_NEG, SEL_DHI, SEL_DLO, SEL_PHI, SEL_PLO: begin
                        lim_q[cfg_chan][cfg_sel[2:0]] <= cfg_data;  // [R2]
                    end
                    SEL_OPT: begin
                        opt_q[cfg_chan] <= cfg_data[OPT_W-1:0];
                    end
                    SEL_REF: begin
                        if (cfg_data < TW'(NREF)) begin
                            ref_sel_q <= cfg_data[REF_AW-1:0];      // [R6]
                        end
                    end
                    SEL_AVG: begin
                        avg_sh_q <= (cfg_data[2:0] > AVG_MAX) ? AVG_MAX : cfg_data[2:0]; // [R8]
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Stroke peaks and references
    // ==========================================================
    ptlm_ton_t         peak_q [NCH];   // Highest reading this stroke.
    ptlm_ton_t         base_q [NCH];   // Process base tonnage.
    logic              base_ok_q;      // Base seeded by one stroke.
    logic [NREF-1:0]   ref_ok_q;       // Entries holding a learned set.
    logic              stroke_on_q;    // A stroke has begun.
    logic [NCH*TW-1:0] ref_word;
    logic [NCH*TW-1:0] learn_word;
    logic              learn_wr;

    ptlm_ref_mem u_ref (
        .clk     (clk),
        .we      (learn_wr),
        .waddr   (ref_sel_q),
        .wdata   (learn_word),
        .raddr   (ref_sel_q),
        .rdata_q (ref_word)
    );

    // Peak tracking restarts at each stroke edge.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int c = 0; c < NCH; c++) begin
                peak_q[c] <= 16'sh8000;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (stroke_edge) begin
                    peak_q[c] <= 16'sh8000;
                end else if (sample_valid && $signed(sample_ton[c*TW +: TW]) > peak_q[c]) begin
                    peak_q[c] <= $signed(sample_ton[c*TW +: TW]);
                end
            end
        end
    end

    // Exponential running average; shift sets the effective stroke count.
    always_ff @(posedge clk) begin
        if (rst) begin
            base_ok_q <= 1'b0;
            for (int c = 0; c < NCH; c++) begin
                base_q[c] <= '0;
            end
        end else if (stroke_edge && stroke_on_q) begin
            base_ok_q <= 1'b1;
            for (int c = 0; c < NCH; c++) begin
                if (!base_ok_q) begin
                    base_q[c] <= peak_q[c];
                end else begin
                    base_q[c] <= TW'(base_q[c] + ((17'(peak_q[c]) - 17'(base_q[c])) >>> avg_sh_q)); // [R8]
                end
            end
        end
    end

    // Learning sums a fixed number of stroke peaks then stores the mean.
    logic [2:0]         learn_cnt_q;
    logic signed [18:0] learn_sum_q [NCH];
    always_ff @(posedge clk) begin
        if (rst) begin
            learn_busy_q <= 1'b0;
            learn_cnt_q  <= '0;
            ref_ok_q     <= '0;
            for (int c = 0; c < NCH; c++) begin
                learn_sum_q[c] <= '0;
            end
        end else if (learn_cmd) begin
            learn_busy_q <= 1'b1;                  // [R9]
            learn_cnt_q  <= '0;
            for (int c = 0; c < NCH; c++) begin
                learn_sum_q[c] <= '0;
            end
        end else if (learn_busy_q && stroke_edge && stroke_on_q) begin
            for (int c = 0; c < NCH; c++) begin
                learn_sum_q[c] <= learn_sum_q[c] + 19'(peak_q[c]);
            end
            learn_cnt_q <= learn_cnt_q + 3'h1;
        end else if (learn_busy_q && learn_cnt_q == LEARN_N) begin
            learn_busy_q        <= 1'b0;
            ref_ok_q[ref_sel_q] <= 1'b1;
        end
    end
    assign learn_wr = learn_busy_q && (learn_cnt_q == LEARN_N) && !learn_cmd;

    // ==========================================================
    // Per-channel comparisons
    // ==========================================================
    logic [NCH-1:0] pos_hit, neg_hit, over_hit, under_hit, drift_hit;

    // Deviation in tons, or as percent of the band centre.
    function automatic logic signed [31:0] dev_of(input ptlm_ton_t ctr,
                                                   input logic [TW-1:0] dev,
                                                   input logic pct);
        logic signed [31:0] prod;
        prod = 32'(ctr) * $signed({16'h0000, dev});
        return pct ? (prod / PCT_FULL) : $signed({16'h0000, dev});
    endfunction

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            ptlm_ton_t          smp, rctr;
            logic signed [31:0] pk, dhi, dlo, phi, plo;
            logic               die_on, prc_on, inst;
            assign smp    = $signed(sample_ton[g*TW +: TW]);
            assign rctr   = $signed(ref_word[g*TW +: TW]);
            assign pk     = 32'(peak_q[g]);
            assign inst   = chan_installed[g];                                 // [R1]
            // Learned mean of four stroke peaks; the arithmetic shift keeps the sign.
            assign learn_word[g*TW +: TW] = TW'(learn_sum_q[g] >>> LEARN_SH);  // [R9]
            assign die_on = opt_q[g][OPT_DIE_EN] && ref_ok_q[ref_sel_q];      // [R5]
            assign prc_on = opt_q[g][OPT_PROC_EN] && base_ok_q;               // [R7]
            assign dhi = 32'(rctr) + dev_of(rctr, lim_q[g][SEL_DHI[2:0]], opt_q[g][OPT_DIE_PCT]);
            assign dlo = 32'(rctr) - dev_of(rctr, lim_q[g][SEL_DLO[2:0]], opt_q[g][OPT_DIE_PCT]);
            assign phi = 32'(base_q[g])
                       + dev_of(base_q[g], lim_q[g][SEL_PHI[2:0]], opt_q[g][OPT_PRC_PCT]);
            assign plo = 32'(base_q[g])
                       - dev_of(base_q[g], lim_q[g][SEL_PLO[2:0]], opt_q[g][OPT_PRC_PCT]);
            // Overload has no enable at all.
            assign pos_hit[g] = inst && sample_valid
                              && smp > $signed(lim_q[g][SEL_POS[2:0]]);        // [R3]
            assign neg_hit[g] = inst && sample_valid && opt_q[g][OPT_NEG_EN]
                              && 32'(smp) < -$signed({16'h0000, lim_q[g][SEL_NEG[2:0]]}); // [R4]
            // Band checks judge the finished stroke's peak.
            assign over_hit[g]  = inst && stroke_edge && stroke_on_q
                                && ((die_on && pk > dhi) || (prc_on && pk > phi));  // [R11]
            assign under_hit[g] = inst && stroke_edge && stroke_on_q
                                && ((die_on && pk < dlo) || (prc_on && pk < plo)); // [R12]
            // An unloaded sensor at the top of stroke must read near zero.
            assign drift_hit[g] = inst && stroke_edge && sample_valid
                                && (smp > $signed(DRIFT_LIMIT) || smp < -$signed(DRIFT_LIMIT));
        end
    endgenerate

    // ==========================================================
    // Fault latches and relays
    // ==========================================================
    logic [NCH-1:0] fault_evt;
    assign fault_evt = chan_installed & (open_s | drift_hit);  // [R19]

    // A new event beats a simultaneous reset so nothing is lost.
    always_ff @(posedge clk) begin
        if (rst) begin
            chan_fault_q <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (fault_evt[c]) begin
                    chan_fault_q[c] <= 1'b1;
                end else if (frst_s) begin
                    chan_fault_q[c] <= 1'b0;                 // [R17]
                end
            end
        end
    end

    // Relays are energized (high) when healthy, so a lost supply reads as alarm.
    always_ff @(posedge clk) begin
        if (rst) begin
            relay_pos_q   <= 1'b1;
            relay_neg_q   <= 1'b1;
            relay_over_q  <= 1'b1;
            relay_under_q <= 1'b1;
            relay_fault_q <= 1'b1;
        end else begin
            relay_pos_q   <= ~(|pos_hit)   & (relay_pos_q   | frst_s);  // [R10] [R20]
            relay_neg_q   <= ~(|neg_hit)   & (relay_neg_q   | frst_s);  // [R10] [R20]
            relay_over_q  <= ~(|over_hit)  & (relay_over_q  | frst_s);  // [R11] [R20]
            relay_under_q <= ~(|under_hit) & (relay_under_q | frst_s);  // [R12] [R20]
            relay_fault_q <= ~(|fault_evt) & (relay_fault_q | frst_s);  // [R19] [R20]
        end
    end

    // ==========================================================
    // Stroke bookkeeping and counters
    // ==========================================================
    logic stroke_bad_q, bad_now;
    assign bad_now = stroke_bad_q | (|pos_hit) | (|neg_hit) | (|over_hit)
                   | (|under_hit) | (|fault_evt) | (|chan_fault_q);

    // Good-part verdict collects every alarm and fault within the stroke.
    always_ff @(posedge clk) begin
        if (rst) begin
            stroke_on_q  <= 1'b0;
            stroke_bad_q <= 1'b0;
            hit_count_q  <= '0;
            good_count_q <= '0;
        end else if (stroke_edge) begin
            stroke_on_q  <= 1'b1;
            stroke_bad_q <= 1'b0;
            if (stroke_on_q) begin
                hit_count_q <= hit_count_q + 32'h0000_0001;      // [R13] [R21]
                if (!bad_now) begin
                    good_count_q <= good_count_q + 32'h0000_0001; // [R13] [R21]
                end
            end
        end else begin
            stroke_bad_q <= bad_now;
        end
    end

    // Percentage lags the counters by one cycle; the costly divide is recomputed every cycle.
    logic [38:0] good_x100;
    assign good_x100 = 39'(good_count_q) * 39'(PCT_FULL);
    always_ff @(posedge clk) begin
        if (rst) begin
            good_pct_q <= '0;
        end else if (hit_count_q == 32'h0000_0000) begin
            good_pct_q <= '0;
        end else begin
            good_pct_q <= 7'(good_x100 / 39'(hit_count_q));   // [R14]
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    sequence s_edge_after_stroke;
        stroke_edge && stroke_on_q;
    endsequence

    property p_pos_drop;
        @(posedge clk) disable iff (rst) (|pos_hit) |=> !relay_pos_q;
    endproperty
    a_pos_drop: assert property (p_pos_drop) else $error("overload relay did not drop"); // [R3]

    property p_neg_off;
        @(posedge clk) disable iff (rst)
            (relay_neg_q && !(|(opt_q[0][0] | opt_q[1][0] | opt_q[2][0] | opt_q[3][0])))
            |=> relay_neg_q;
    endproperty
    a_neg_off: assert property (p_neg_off) else $error("reverse relay dropped while off"); // [R4]

    property p_over;
        @(posedge clk) disable iff (rst) (|over_hit) |=> !relay_over_q ##1 1'b1;
    endproperty
    a_over: assert property (p_over) else $error("over relay did not drop"); // [R11]

    property p_under;
        @(posedge clk) disable iff (rst) $fell(relay_under_q) |-> $past(|under_hit);
    endproperty
    a_under: assert property (p_under) else $error("under relay dropped without cause"); // [R12]

    property p_hits;
        @(posedge clk) disable iff (rst)
            s_edge_after_stroke |=> hit_count_q == $past(hit_count_q) + 32'h0000_0001;
    endproperty
    a_hits: assert property (p_hits) else $error("hit count not advanced"); // [R21]

    property p_refuse;
        @(posedge clk) disable iff (rst)
            (cfg_wr && !prog_s) |=> cfg_refused_q && $stable(ref_sel_q) && $stable(avg_sh_q);
    endproperty
    a_refuse: assert property (p_refuse) else $error("write taken without enable"); // [R15]

    property p_priv;
        @(posedge clk) disable iff (rst) (cfg_wr && !supv_s && priv_sel) |=> $stable(ref_sel_q);
    endproperty
    a_priv: assert property (p_priv) else $error("privileged write taken"); // [R16]

    property p_hold;
        @(posedge clk) disable iff (rst) (!relay_over_q && !frst_s) |=> !relay_over_q;
    endproperty
    a_hold: assert property (p_hold) else $error("relay re-energized without reset"); // [R20]

    property p_open;
        @(posedge clk) disable iff (rst)
            (chan_installed[0] && sensor_open[0]) [*3] |=> ##[0:1] !relay_fault_q;
    endproperty
    a_open: assert property (p_open) else $error("broken wire not flagged"); // [R19]
endmodule
`default_nettype wire

// [bench/ptlm_sensor_model.sv]
// Behavioural sensor front end that feeds tonnage samples.
`timescale 1ns/1ps
`default_nettype none
module ptlm_sensor_model
    import ptlm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              req,
    input  wire logic [NCH*TW-1:0] load,
    output logic                   sample_valid,
    output logic [NCH*TW-1:0]      sample_ton
);
    // One reading set per request; outputs follow the falling-edge request directly.
    // Between requests the bus shows the inverse, so a stale reading never looks fresh.
    assign sample_valid = req;
    assign sample_ton   = req ? load : ~load;
endmodule
`default_nettype wire

// [bench/tb_press_tonnage_limit_monitor.sv]
// Self-checking bench for the press tonnage limit monitor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb_press_tonnage_limit_monitor
    import ptlm_pkg::*;
;
    // ==========================================================
    // Stimulus and observed signals
    // ==========================================================
    logic clk = 0, rst = 1, req = 0, cfg_wr = 0, program_enable = 0;
    logic supv1 = 0, supv2 = 0, fault_reset = 0, press_cycle = 0;
    logic [3:0] cfg_sel = '0, sensor_open = '0, chan_installed = 4'h1;
    logic [1:0] cfg_chan = '0;
    logic [15:0] cfg_data = '0;
    logic [63:0] load = '0, sample_ton;
    logic sample_valid, relay_pos_q, relay_neg_q, relay_over_q, relay_under_q, relay_fault_q;
    logic learn_busy_q, cfg_refused_q;
    logic [3:0] chan_fault_q;
    logic [31:0] hit_count_q, good_count_q;
    logic [6:0] good_pct_q;
    int n_fail = 0, tests_run = 0, ncyc = 0;

    ptlm_sensor_model ptlm_sensor_model_inst (.clk, .req, .load, .sample_valid, .sample_ton);
    ptlm_monitor ptlm_monitor_inst (.clk, .rst, .sample_valid, .sample_ton, .chan_installed,
        .cfg_wr, .cfg_chan, .cfg_sel, .cfg_data, .program_enable, .supv1, .supv2, .fault_reset,
        .press_cycle, .sensor_open, .relay_pos_q, .relay_neg_q, .relay_over_q, .relay_under_q,
        .relay_fault_q, .chan_fault_q, .hit_count_q, .good_count_q, .good_pct_q, .learn_busy_q,
        .cfg_refused_q);

    // 100 MHz clock.
    always #5 clk = ~clk;

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    // One write; the refusal pulse is due one cycle later.
    task automatic wr(logic [3:0] sel, logic [15:0] d, logic rf);
        cfg_sel = sel;
        cfg_data = d;
        cfg_wr = 1;
        cyc(1);
        cfg_wr = 0;
        `CHK("refused", rf, cfg_refused_q)
        cyc(1);
    endtask
    // A press stroke mark; the pin passes two flops before it counts.
    task automatic strike();
        press_cycle = 1;
        cyc(2);
        press_cycle = 0;
        cyc(6);
    endtask
    // A channel 0 reading; the other channels are uninstalled and carry junk.
    task automatic sample(logic [15:0] t);
        load = {48'h7fff_7fff_7fff, t};
        req = 1;
        cyc(1);
        req = 0;
        cyc(4);
    endtask
    task automatic counts(logic [31:0] h, logic [31:0] g, logic [6:0] p);
        `CHK("hits", h, hit_count_q)
        `CHK("good", g, good_count_q)
        `CHK("pct", p, good_pct_q)
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_access();
        wr(SEL_POS, 16'h0064, 1'b1);
        program_enable = 1;
        cyc(3);
        wr(SEL_AVG, 16'h0003, 1'b1);
        supv1 = 1;
        supv2 = 1;
        cyc(3);
        wr(SEL_AVG, 16'h0003, 1'b0);
        wr(SEL_POS, 16'h0064, 1'b0);
    endtask
    task automatic t_over();
        sample(16'h0064);
        `CHK("pos equal", 1'b1, relay_pos_q)
        sample(16'h00c8);
        `CHK("pos over", 1'b0, relay_pos_q)
        cyc(5);
        `CHK("pos held", 1'b0, relay_pos_q)
        strike();
        counts(32'h0000_0002, 32'h0000_0001, 7'h32);
        fault_reset = 1;
        cyc(4);
        `CHK("pos cleared", 1'b1, relay_pos_q)
        fault_reset = 0;
    endtask

    task automatic t_neg();
        wr(SEL_NEG, 16'h0032, 1'b0);
        sample(16'hff9c);
        `CHK("neg off", 1'b1, relay_neg_q)
        wr(SEL_OPT, 16'h0001, 1'b0);
        sample(16'hff9c);
        `CHK("neg over", 1'b0, relay_neg_q)
    endtask
    // Four strokes peaking at 80 tons give a reference of 80; the band is 70 to 90.
    task automatic t_learn();
        wr(SEL_LEARN, 16'h0000, 1'b0);
        `CHK("learning", 1'b1, learn_busy_q)
        repeat (4) begin
            sample(16'h0050);
            strike();
        end
        `CHK("learned", 1'b0, learn_busy_q)
        wr(SEL_DHI, 16'h000a, 1'b0);
        wr(SEL_DLO, 16'h000a, 1'b0);
        wr(SEL_OPT, 16'h0003, 1'b0);
        sample(16'h0064);
        strike();
        `CHK("over", 2'h1, {relay_over_q, relay_under_q})
        sample(16'h0032);
        strike();
        `CHK("under", 2'h0, {relay_over_q, relay_under_q})
    endtask
    task automatic t_fault();
        sensor_open = 4'h1;
        cyc(3);
        sensor_open = 4'h0;
        cyc(4);
        `CHK("wire", 5'h01, {relay_fault_q, chan_fault_q})
        fault_reset = 1;
        cyc(4);
        fault_reset = 0;
        `CHK("cleared", 9'h1f0, {relay_pos_q, relay_neg_q, relay_over_q, relay_under_q,
            relay_fault_q, chan_fault_q})
    endtask

    // The single place where the run ends.
    task automatic results();
        if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // A hang counts as a mismatch; the tests need about one hundred and eighty cycles.
    always @(posedge clk) begin
        ncyc++;
        if (ncyc == 3000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        cyc(10);
        rst = 0;
        cyc(3);
        `CHK("relays", 5'h1f, {relay_pos_q, relay_neg_q, relay_over_q, relay_under_q,
            relay_fault_q})
        counts(32'h0000_0000, 32'h0000_0000, 7'h00);
        t_access();
        strike();
        strike();
        counts(32'h0000_0001, 32'h0000_0001, 7'h64);
        t_over();
        t_neg();
        t_learn();
        t_fault();
        results();
    end
endmodule
`default_nettype wire
